// ==== shared/expansion_defs.svh ====
// offsets, field positions, reset values and masks of the expansion status register
// assumes an apb slave on pclk, 32-bit data, one aligned word per register
//
// Contract
// - expansion status is 16-bit register at 0x06
// - reserved bits 15:5 always read zero
// - reserved writes pass only while override set
// - bit 4 set on parallel detection fault
// - bit 4 is sticky until read
// - bit 3 mirrors partner next page bit
// - bit 2 reads one, local next page able
// - bit 1 set when new page stored
// - reading register clears page received bit
// - bit 1 is sticky until read
// - bit 0 set once valid bursts received
// - reset value zero except bit 2 one
`ifndef EXPANSION_DEFS_SVH
`define EXPANSION_DEFS_SVH

// register index of the status word; its byte address is four times the index
`define EXP_STATUS_INDEX 8'h06
`define EXP_STATUS_OFFSET 8'h18
`define EXP_IRQ_STATUS_OFFSET 8'h10
`define EXP_IRQ_MASK_OFFSET 8'h14

`define EXP_BIT_PD_FAULT 4
`define EXP_BIT_LP_NP_ABLE 3
`define EXP_BIT_NP_ABLE 2
`define EXP_BIT_PAGE_RX 1
`define EXP_BIT_LP_AN_ABLE 0

`define EXP_STATUS_RESET 16'h0004
`define EXP_RESERVED_MASK 16'hffe0
`define EXP_EVENT_MASK 5'h12

`endif

// ==== shared/expansion_pkg.sv ====
// types shared by the expansion status block
// assumes expansion_defs.svh supplies the numbers
package expansion_pkg;

   // the five live status bits of the register
   typedef struct packed {
      logic pd_fault;
      logic lp_np_able;
      logic np_able;
      logic page_rx;
      logic lp_an_able;
   } status_s;

   // raw event inputs from the negotiation logic
   typedef struct packed {
      logic pd_fault;
      logic lp_np_bit;
      logic page_stored;
      logic flp_valid;
   } event_s;

   typedef enum logic [1:0] {
      apb_idle = 2'b00,
      apb_access = 2'b01
   } apb_phase_e;

endpackage

// ==== core/sticky_bit.sv ====
// one latching-high flag: set by an event, cleared by a read
// assumes event and clear are on pclk; set wins over clear
`timescale 1ns/1ps
`include "expansion_defs.svh"
module sticky_bit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_in,
   input wire logic clear_in,
   output logic flag
);
   logic next_flag;

   ///////////////////////////////////////////////////////////////////
   // set beats clear so an event in the read cycle is kept
   always_comb
   begin
      next_flag = flag;
      if (clear_in)
      begin
         next_flag = 1'b0;
      end
      if (set_in)
      begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
      end
   end

   AST_STICKY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      flag && !clear_in |=> flag)
      else $error("sticky flag dropped without a read");
endmodule // sticky_bit

// ==== core/sync2.sv ====
// two-flop synchroniser for a group of level inputs
// assumes inputs arrive from outside the pclk domain
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   ///////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always_comb
   begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule // sync2

// ==== core/autoneg_expansion_status.sv ====
// apb register bank for the negotiation expansion status register
// assumes a single-clock apb master; event inputs come from another domain
`timescale 1ns/1ps
`include "expansion_defs.svh"
module autoneg_expansion_status (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic override_enable,
   input wire logic pd_fault_in,
   input wire logic lp_np_bit_in,
   input wire logic page_stored_in,
   input wire logic flp_valid_in,
   output logic irq
);
   expansion_pkg::event_s ev_raw;
   expansion_pkg::event_s ev;
   expansion_pkg::status_s st;
   logic [3:0] ev_sync;
   logic ovr_sync;
   logic [10:0] reserved;
   logic [10:0] next_reserved;
   logic [4:0] irq_status;
   logic [4:0] next_irq_status;
   logic [4:0] irq_mask;
   logic [4:0] next_irq_mask;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic access;
   logic wr;
   logic rd;
   logic rd_status;
   logic rd_irq;
   logic pd_flag;
   logic page_flag;
   logic ovr_meta;
   logic next_ovr_meta;
   logic next_ovr_sync;

   // address match used by both read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   ///////////////////////////////////////////////////////////////////
   // pin inputs pass two flops before use
   assign ev_raw = '{pd_fault: pd_fault_in, lp_np_bit: lp_np_bit_in,
                     page_stored: page_stored_in, flp_valid: flp_valid_in};

   sync2 #(.WIDTH(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(ev_raw),
      .sync_out(ev_sync)
   );
   assign ev = ev_sync;

   // override bit lives in another register, so it is a pin here
   always_comb
   begin
      next_ovr_meta = override_enable;
      next_ovr_sync = ovr_meta;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovr_meta <= 1'b0;
         ovr_sync <= 1'b0;
      end
      else
      begin
         ovr_meta <= next_ovr_meta;
         ovr_sync <= next_ovr_sync;
      end
   end

   ///////////////////////////////////////////////////////////////////
   // apb decode: zero wait states, access phase completes at once
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign rd_status = rd && hit(paddr, `EXP_STATUS_OFFSET);
   assign rd_irq = rd && hit(paddr, `EXP_IRQ_STATUS_OFFSET);
   assign pready = 1'b1;

   ///////////////////////////////////////////////////////////////////
   // latching-high bits, cleared by a read of the status register
   sticky_bit u_pd (
      .pclk(pclk),
      .presetn(presetn),
      .set_in(ev.pd_fault),
      .clear_in(rd_status),
      .flag(pd_flag)
   );

   sticky_bit u_page (
      .pclk(pclk),
      .presetn(presetn),
      .set_in(ev.page_stored),
      .clear_in(rd_status),
      .flag(page_flag)
   );

   // sticky bits show event or latched value, so a read re-tracks the level
   assign st.pd_fault = pd_flag || ev.pd_fault;
   assign st.page_rx = page_flag || ev.page_stored;
   assign st.lp_np_able = ev.lp_np_bit;
   assign st.np_able = 1'b1;
   assign st.lp_an_able = ev.flp_valid;

   ///////////////////////////////////////////////////////////////////
   // reserved storage: writable only under override, never read back
   always_comb
   begin
      next_reserved = reserved;
      if (wr && hit(paddr, `EXP_STATUS_OFFSET) && ovr_sync && pstrb[1] && pstrb[0])
      begin
         next_reserved = pwdata[15:5];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reserved <= '0;
      end
      else
      begin
         reserved <= next_reserved;
      end
   end

   ///////////////////////////////////////////////////////////////////
   // interrupt status and mask: events set, read clears, set wins
   always_comb
   begin
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      if (rd_irq)
      begin
         next_irq_status = '0;
      end
      next_irq_status[`EXP_BIT_PD_FAULT] = next_irq_status[`EXP_BIT_PD_FAULT] | ev.pd_fault;
      next_irq_status[`EXP_BIT_PAGE_RX] = next_irq_status[`EXP_BIT_PAGE_RX] | ev.page_stored;
      if (wr && hit(paddr, `EXP_IRQ_MASK_OFFSET) && pstrb[0])
      begin
         next_irq_mask = pwdata[4:0] & `EXP_EVENT_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= '0;
         irq_mask <= '0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
      end
   end

   assign irq = |(irq_status & irq_mask);

   ///////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero with pslverr
   always_comb
   begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      if (psel && !penable)
      begin
         if (hit(paddr, `EXP_STATUS_OFFSET))
         begin
            next_prdata = {16'h0000, 11'h000, st};
         end
         else if (hit(paddr, `EXP_IRQ_STATUS_OFFSET))
         begin
            next_prdata = {27'h0000000, next_irq_status}; // an event in setup shows in the read data before the clear
         end
         else if (hit(paddr, `EXP_IRQ_MASK_OFFSET))
         begin
            next_prdata = {27'h0000000, irq_mask};
         end
         else
         begin
            next_pslverr = 1'b1;
         end
      end
      else
      begin
         next_prdata = prdata;
         next_pslverr = pslverr;
      end
   end

   // data captured in setup so the access phase answers with no wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   ///////////////////////////////////////////////////////////////////
   AST_RES_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status |-> prdata[15:5] == 11'h000)
      else $error("reserved bits read nonzero");

   AST_NP_ABLE: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status |-> prdata[`EXP_BIT_NP_ABLE])
      else $error("local next page able not one");

   AST_OVR_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      !ovr_sync |=> $stable(reserved))
      else $error("reserved bits changed without override");

   AST_PD_SET: assert property (@(posedge pclk) disable iff (!presetn)
      ev.pd_fault |=> pd_flag)
      else $error("fault did not latch");

   AST_PAGE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status && !ev.page_stored |=> !page_flag)
      else $error("page flag not cleared by read");

   AST_PAGE_SET: assert property (@(posedge pclk) disable iff (!presetn)
      ev.page_stored |=> page_flag [*1] ##0 st.page_rx)
      else $error("page received not set");

   AST_LP_NP: assert property (@(posedge pclk) disable iff (!presetn)
      st.lp_np_able == ev_sync[2])
      else $error("partner next page bit mismatch");

   AST_AN_ABLE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ev_sync[0]) |-> st.lp_an_able)
      else $error("partner negotiation able not set");

   AST_RESET_VAL: assert property (@(posedge pclk)
      $rose(presetn) |-> reserved == 11'h000 && !pd_flag && !page_flag)
      else $error("bad reset value");

   AST_STICKY_LVL: assert property (@(posedge pclk) disable iff (!presetn)
      pd_flag && !rd_status |=> st.pd_fault)
      else $error("fault bit not sticky");

   AST_PAGE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      page_flag && !rd_status |=> st.page_rx)
      else $error("page bit not sticky");

   AST_PD_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status && !ev.pd_fault |=> !pd_flag)
      else $error("fault flag not cleared by read");

   AST_PD_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
      !pd_flag |-> st.pd_fault == ev.pd_fault)
      else $error("fault bit does not follow the event");

   AST_PAGE_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
      !page_flag |-> st.page_rx == ev.page_stored)
      else $error("page bit does not follow the event");

   AST_AN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      !ev_sync[0] |-> !st.lp_an_able)
      else $error("partner negotiation able set without bursts");

   AST_STATUS_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status |-> prdata[31:16] == 16'h0000)
      else $error("status word wider than 16 bits");

   AST_STATUS_OK: assert property (@(posedge pclk) disable iff (!presetn)
      rd_status |-> !pslverr)
      else $error("status read flagged as error");

   AST_RES_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit(paddr, `EXP_STATUS_OFFSET) && ovr_sync && pstrb[1] && pstrb[0]
      |=> reserved == $past(pwdata[15:5]))
      else $error("reserved write lost under override");

   AST_PD_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && hit(paddr, `EXP_STATUS_OFFSET) && ev.pd_fault
      |=> prdata[`EXP_BIT_PD_FAULT])
      else $error("fault missing from read data");

   AST_PAGE_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && hit(paddr, `EXP_STATUS_OFFSET) && ev.page_stored
      |=> prdata[`EXP_BIT_PAGE_RX])
      else $error("page received missing from read data");

   AST_LP_NP_READ: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && hit(paddr, `EXP_STATUS_OFFSET)
      |=> prdata[`EXP_BIT_LP_NP_ABLE] == $past(ev.lp_np_bit))
      else $error("partner next page bit wrong in read data");
endmodule // autoneg_expansion_status

// ==== verif/sta_model.sv ====
// station management model: an apb master that reaches the register bank
// assumes pclk comes from the bench; the slave may insert wait states
`timescale 1ns/1ps
module sta_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   bit tmo = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // idle bus from time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end

   // one transfer; reserved bits go out as zero unless raw asks otherwise
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input bit raw, output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= raw ? wd : (wd & 32'h0000001f);
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      tmo = (n >= 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // an idle edge keeps two transfers from driving psel in one time step
      @(posedge pclk);
   endtask
endmodule // sta_model

// ==== verif/autoneg_expansion_status_tb.sv ====
// self-checking bench of the expansion status register bank
// assumes the sta_model master and the design's pin-level event inputs
`timescale 1ns/1ps
`define CHK(n, x, g) tests_run++; if ((g) !== (x)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, x, g); end
module autoneg_expansion_status_tb;
   localparam int STATUS_IDX = 6;
   localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [3:0] pstrb;
   logic override_enable = 1'b0;
   logic pd = 1'b0;
   logic np = 1'b0;
   logic pg = 1'b0;
   logic flp = 1'b0;
   logic e;
   logic [4:0] ev;
   logic [1:0] lat;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 47898;

   ////////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   always #5 pclk = ~pclk;

   sta_model i_sta_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   autoneg_expansion_status i_autoneg_expansion_status (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .override_enable(override_enable), .pd_fault_in(pd), .lp_np_bit_in(np),
      .page_stored_in(pg), .flp_valid_in(flp), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // expected register image: sticky bits are latch or live level
   function automatic logic [31:0] exp_status(input logic [4:0] v, input logic [1:0] l);
      return {27'h0, l[1], v[1], 1'b1, l[0], v[3]};
   endfunction

   task automatic test_done();
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd, input bit raw);
      i_sta_model.xfer(w, a, wd, raw, d, e);
      if (i_sta_model.tmo)
      begin
         fail_count++;
         test_done();
      end
   endtask

   // events pass a two-flop synchroniser, so settle a few edges before looking
   task automatic set_ev(input logic [4:0] v);
      override_enable <= v[4];
      pd <= v[0];
      np <= v[1];
      pg <= v[2];
      flp <= v[3];
      repeat (6) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      acc(1'b0, STATUS_ADDR, 32'h0, 1'b0);
      `CHK("reset value", 32'h00000004, d)
      `CHK("reset irq", 1'b0, irq)
      // reserved writes with the override low, then high, never read back
      for (int i = 0; i < 2; i++)
      begin
         set_ev(5'(i << 4));
         acc(1'b1, STATUS_ADDR, 32'h0000ffff, 1'b1);
         acc(1'b0, STATUS_ADDR, 32'h0, 1'b0);
         `CHK("reserved bits", 32'h00000004, d)
      end
      acc(1'b0, 8'h20, 32'h0, 1'b0);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0, d)
      // page event through an enabled mask, then a read-clear
      acc(1'b1, 8'h14, 32'h00000012, 1'b0);
      set_ev(5'h04);
      set_ev(5'h00);
      `CHK("irq page", 1'b1, irq)
      acc(1'b0, 8'h10, 32'h0, 1'b0);
      `CHK("irq status", 32'h00000002, d)
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      // masked fault stays quiet until unmasked
      acc(1'b1, 8'h14, 32'h0, 1'b0);
      set_ev(5'h01);
      `CHK("irq masked", 1'b0, irq)
      acc(1'b1, 8'h14, 32'h00000010, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("irq unmasked", 1'b1, irq)
      acc(1'b0, 8'h10, 32'h0, 1'b0);
      `CHK("irq fault status", 32'h00000010, d)
      lat = 2'b11;
      // random event levels, each read compared against the sticky model
      repeat (40)
      begin
         ev = 5'($random(seed));
         set_ev(ev);
         lat = lat | {ev[0], ev[2]};
         acc(1'b0, STATUS_ADDR, 32'h0, 1'b0);
         `CHK("status", exp_status(ev, lat), d)
         `CHK("status error", 1'b0, e)
         lat = {ev[0], ev[2]};
      end
      test_done();
   end
endmodule // autoneg_expansion_status_tb
